/* rtl/css_defines.svh */
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// Register offsets (byte addresses, one word each)
`define CSS_CTRL_OFF 8'h00
`define CSS_STATUS_OFF 8'h04

// Control register fields
`define CSS_CTRL_CORE_OFF 0
`define CSS_CTRL_PERIPH_OFF 1
`define CSS_CTRL_CONV_OFF 2
`define CSS_CTRL_TIMER_OFF 3
`define CSS_CTRL_SLEEP 4
`define CSS_CTRL_RESET 4'h0

// Status register fields
`define CSS_ST_STATE_LSB 0
`define CSS_ST_SRCSEL_LSB 3
`define CSS_ST_SUSEL_LSB 7
`define CSS_ST_DIV8 9
`define CSS_ST_SRC_LSB 10
`define CSS_ST_RESET 13
`define CSS_ST_WOKE 14

// Factory fuse values, used when the fuse array reads back invalid
`define CSS_FACTORY_SRCSEL 4'h2
`define CSS_FACTORY_SUSEL 2'h2
`define CSS_FACTORY_DIV8 1'b0

// Synchronised pin indices and their idle levels
`define CSS_PIN_EXT_RST 0
`define CSS_PIN_WDT 1
`define CSS_PIN_OSC 2
`define CSS_PIN_XTAL 3
`define CSS_PIN_IDLE 4'h1

// Time-out codes and watchdog oscillator cycle counts
`define CSS_TO_NONE 2'h0
`define CSS_TO_SHORT 2'h1
`define CSS_TO_LONG 2'h2
`define CSS_TO_SHORT_CYC 16'h0200
`define CSS_TO_LONG_CYC 16'h2000

// Oscillator start-up cycle counts
`define CSS_SU_EXT 16'h0006
`define CSS_SU_258 16'h0102
`define CSS_SU_1K 16'h0400
`define CSS_SU_16K 16'h4000
`define CSS_SU_32K 16'h8000
`define CSS_SU_RESET_EXTRA 16'h000e

// System clock prescaler
`define CSS_DIV8_LAST 3'h7

`endif

/* rtl/css_pkg.sv */
package css_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RESET,
        ST_TIMEOUT,
        ST_STARTUP,
        ST_RUN,
        ST_SLEEP
    } css_state_type;

    // Decoded clock source
    typedef enum logic [2:0] {
        SRC_LP_XTAL,
        SRC_FS_XTAL,
        SRC_LF_XTAL,
        SRC_RC_128K,
        SRC_RC_CAL,
        SRC_EXT,
        SRC_RESERVED
    } css_source_type;

endpackage : css_pkg

/* rtl/css_startup_sequencer.sv */
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`include "css_defines.svh"
module css_startup_sequencer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Asynchronous pins and foreign clocks
    input wire logic ext_reset_n_pin,
    input wire logic watchdog_osc_in,
    input wire logic osc_clk_in,
    input wire logic async_xtal_in,
    // Configuration fuses
    input wire logic [3:0] clock_source_select_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic divide_by_eight_fuse,
    input wire logic fuses_valid,
    // Wake sources
    input wire logic wake_event,
    input wire logic level_irq_in,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Reset and clock enables towards the core
    output logic internal_reset,
    output logic core_clock_en,
    output logic peripheral_clock_en,
    output logic program_memory_clock_en,
    output logic converter_clock_en,
    output logic async_timer_clock_en,
    // Decoded configuration and wake interrupt
    output logic [2:0] source_select,
    output logic [2:0] osc_range,
    output logic wake_irq_taken
);

    css_pkg::css_state_type state_reg; // Sequencer state
    logic [15:0] cnt_reg; // Shared time-out / start-up counter
    logic woke_reg; // Current start-up is a wake
    logic [3:0] src_sel_reg; // Latched source select
    logic [1:0] su_sel_reg; // Latched start-up select
    logic div8_reg; // Latched divide fuse, zero = programmed
    logic [3:0] ctrl_reg; // Software clock gates
    logic sleep_req_reg; // One-cycle sleep request
    logic ack_reg; // Bus acknowledge
    logic [31:0] rdat_reg; // Bus read data
    logic [2:0] div_reg; // Prescaler count
    logic tick_reg; // Prescaled system clock tick
    logic irq_reg; // Wake interrupt pulse
    logic rst_out_reg; // Internal reset
    logic [4:0] en_reg; // Clock enables
    logic [2:0] src_reg; // Decoded source
    logic [3:0] s0_reg, s1_reg, s2_reg; // Pin synchronisers
    logic [3:0] filt_reg; // Agreed pin levels
    logic [3:0] rise_reg; // One-cycle rising edges
    logic [17:0] timing; // Decoded {time-out code, start-up cycles}
    logic [15:0] to_target; // Watchdog cycles to wait
    logic [15:0] su_target; // Oscillator cycles to wait
    logic run_state; // Core may run
    logic bus_req; // Bus access pending

    // Source decode, ones mean unprogrammed fuses
    function automatic logic [2:0] source_of(input logic [3:0] cs);
        logic [2:0] s;
        s = 3'(css_pkg::SRC_RESERVED);
        if (cs[3])
            s = 3'(css_pkg::SRC_LP_XTAL);
        else if (cs[3:1] == 3'h3)
            s = 3'(css_pkg::SRC_FS_XTAL);
        else if (cs[3:1] == 3'h2)
            s = 3'(css_pkg::SRC_LF_XTAL);
        else if (cs == 4'h3)
            s = 3'(css_pkg::SRC_RC_128K);
        else if (cs == 4'h2)
            s = 3'(css_pkg::SRC_RC_CAL);
        else if (cs == 4'h0)
            s = 3'(css_pkg::SRC_EXT);
        return s;
    endfunction : source_of

    // Time-out code and start-up cycle count per source and fuses
    function automatic logic [17:0] timing_of(input logic [3:0] cs,
                                               input logic [1:0] su);
        logic [1:0] t;
        logic [15:0] n;
        t = `CSS_TO_LONG;
        n = `CSS_SU_EXT;
        if (cs[3] || cs[3:1] == 3'h3) begin
            // Both crystal amplifiers share one table
            unique case ({cs[0], su})
                3'h0: begin n = `CSS_SU_258; t = `CSS_TO_SHORT; end
                3'h1: begin n = `CSS_SU_258; t = `CSS_TO_LONG; end
                3'h2: begin n = `CSS_SU_1K; t = `CSS_TO_NONE; end
                3'h3: begin n = `CSS_SU_1K; t = `CSS_TO_SHORT; end
                3'h4: begin n = `CSS_SU_1K; t = `CSS_TO_LONG; end
                3'h5: begin n = `CSS_SU_16K; t = `CSS_TO_NONE; end
                3'h6: begin n = `CSS_SU_16K; t = `CSS_TO_SHORT; end
                3'h7: begin n = `CSS_SU_16K; t = `CSS_TO_LONG; end
            endcase
        end else if (cs[3:1] == 3'h2) begin
            // Watch crystal; reserved 11 takes the safest delay
            n = cs[0] ? `CSS_SU_32K : `CSS_SU_1K;
            if (su == 2'h0)
                t = `CSS_TO_NONE;
            else if (su == 2'h1)
                t = `CSS_TO_SHORT;
        end else begin
            // RC and external clocks: short count, fuse picks delay
            if (su == 2'h0)
                t = `CSS_TO_NONE;
            else if (su == 2'h1)
                t = `CSS_TO_SHORT;
        end
        return {t, n};
    endfunction : timing_of

    // Targets follow latched fuses, plus the wake flag for start-up
    always_comb begin
        timing = timing_of(src_sel_reg, su_sel_reg);
        unique case (timing[17:16])
            `CSS_TO_NONE: to_target = 16'h0000;
            `CSS_TO_SHORT: to_target = `CSS_TO_SHORT_CYC;
            default: to_target = `CSS_TO_LONG_CYC;
        endcase
        // Reset start-ups add the fixed 14-cycle tail
        su_target = woke_reg ? timing[15:0]
                             : timing[15:0] + `CSS_SU_RESET_EXTRA;
        run_state = (state_reg == css_pkg::ST_RUN);
        bus_req = wb_cyc_i && wb_stb_i;
    end

    // Three-stage synchronisers; a level counts once stages 2 and 3 agree
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                // Start at the idle level so release shows no false edge
                s0_reg[i] <= 1'(`CSS_PIN_IDLE >> i);
                s1_reg[i] <= 1'(`CSS_PIN_IDLE >> i);
                s2_reg[i] <= 1'(`CSS_PIN_IDLE >> i);
                filt_reg[i] <= 1'(`CSS_PIN_IDLE >> i);
                rise_reg[i] <= 1'b0;
            end else begin
                s0_reg[i] <= i == 0 ? ext_reset_n_pin :
                             i == 1 ? watchdog_osc_in :
                             i == 2 ? osc_clk_in : async_xtal_in;
                s1_reg[i] <= s0_reg[i];
                s2_reg[i] <= s1_reg[i];
                // Only agreed levels move the filter, masking glitches
                if (s1_reg[i] == s2_reg[i])
                    filt_reg[i] <= s2_reg[i];
                rise_reg[i] <= (s1_reg[i] == s2_reg[i]) && s2_reg[i]
                               && !filt_reg[i];
            end
        end
    end

    // Fuses are sampled only under reset so a glitching array
    // cannot retarget the clock while the core runs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            src_sel_reg <= fuses_valid ? clock_source_select_fuses
                                       : `CSS_FACTORY_SRCSEL;
            su_sel_reg <= fuses_valid ? startup_time_fuses
                                      : `CSS_FACTORY_SUSEL;
            div8_reg <= fuses_valid ? divide_by_eight_fuse
                                    : `CSS_FACTORY_DIV8;
        end
    end

    // Start-up sequencing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= css_pkg::ST_RESET;
            cnt_reg <= 16'h0000;
            woke_reg <= 1'b0;
        end else if (!filt_reg[`CSS_PIN_EXT_RST]) begin
            // External reset pin held: restart from scratch
            state_reg <= css_pkg::ST_RESET;
            cnt_reg <= 16'h0000;
            woke_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                css_pkg::ST_RESET: begin
                    cnt_reg <= 16'h0000;
                    woke_reg <= 1'b0;
                    if (to_target == 16'h0000)
                        state_reg <= css_pkg::ST_STARTUP;
                    else
                        state_reg <= css_pkg::ST_TIMEOUT;
                end
                css_pkg::ST_TIMEOUT: begin
                    // Counted on watchdog oscillator edges only
                    if (rise_reg[`CSS_PIN_WDT]) begin
                        if (cnt_reg == to_target - 16'h0001) begin
                            cnt_reg <= 16'h0000;
                            state_reg <= css_pkg::ST_STARTUP;
                        end else begin
                            cnt_reg <= cnt_reg + 16'h0001;
                        end
                    end
                end
                css_pkg::ST_STARTUP: begin
                    // Ripple count of the selected oscillator
                    if (rise_reg[`CSS_PIN_OSC]) begin
                        if (cnt_reg == su_target - 16'h0001) begin
                            cnt_reg <= 16'h0000;
                            state_reg <= css_pkg::ST_RUN;
                        end else begin
                            cnt_reg <= cnt_reg + 16'h0001;
                        end
                    end
                end
                css_pkg::ST_RUN: begin
                    if (sleep_req_reg)
                        state_reg <= css_pkg::ST_SLEEP;
                end
                css_pkg::ST_SLEEP: begin
                    // Supply assumed good: skip the time-out
                    if (wake_event || level_irq_in) begin
                        state_reg <= css_pkg::ST_STARTUP;
                        woke_reg <= 1'b1;
                        cnt_reg <= 16'h0000;
                    end
                end
            endcase
        end
    end

    // Reset output and wake interrupt
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_out_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            rst_out_reg <= !(run_state
                             || state_reg == css_pkg::ST_SLEEP);
            // The level is judged only at the end of start-up
            irq_reg <= state_reg == css_pkg::ST_STARTUP && woke_reg
                       && rise_reg[`CSS_PIN_OSC]
                       && cnt_reg == su_target - 16'h0001
                       && level_irq_in;
        end
    end

    // System clock prescaler
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_reg <= 3'h0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            // Programmed fuse reads zero
            tick_reg <= div8_reg || div_reg == `CSS_DIV8_LAST;
        end
    end

    // Clock distribution; every domain except the async timer uses the same prescaler tick
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_reg <= 5'h00;
        end else begin
            en_reg[0] <= tick_reg && run_state
                         && !ctrl_reg[`CSS_CTRL_CORE_OFF];
            en_reg[1] <= tick_reg && run_state
                         && !ctrl_reg[`CSS_CTRL_CORE_OFF];
            en_reg[2] <= tick_reg && run_state
                         && !ctrl_reg[`CSS_CTRL_PERIPH_OFF];
            // Converter keeps running while core sleeps
            en_reg[3] <= tick_reg && !ctrl_reg[`CSS_CTRL_CONV_OFF]
                         && (run_state
                             || state_reg == css_pkg::ST_SLEEP);
            // Own crystal, ignores sleep and reset sequencing
            en_reg[4] <= rise_reg[`CSS_PIN_XTAL]
                         && !ctrl_reg[`CSS_CTRL_TIMER_OFF];
        end
    end

    // Decoded configuration outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            src_reg <= 3'h0;
        end else begin
            src_reg <= source_of(src_sel_reg);
        end
    end

    // Wishbone: ack one cycle after the strobe, write on the ack edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req && !ack_reg;
            rdat_reg <= 32'h0000_0000;
            if (bus_req && !ack_reg && !wb_we_i) begin
                if (wb_adr_i == `CSS_CTRL_OFF)
                    rdat_reg[3:0] <= ctrl_reg;
                else if (wb_adr_i == `CSS_STATUS_OFF) begin
                    rdat_reg[`CSS_ST_STATE_LSB +: 3] <= 3'(state_reg);
                    rdat_reg[`CSS_ST_SRCSEL_LSB +: 4] <= src_sel_reg;
                    rdat_reg[`CSS_ST_SUSEL_LSB +: 2] <= su_sel_reg;
                    rdat_reg[`CSS_ST_DIV8] <= div8_reg;
                    rdat_reg[`CSS_ST_SRC_LSB +: 3] <= src_reg;
                    rdat_reg[`CSS_ST_RESET] <= rst_out_reg;
                    rdat_reg[`CSS_ST_WOKE] <= woke_reg;
                end
            end
        end
    end

    // Control register; sleep bit is a self-clearing strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_reg <= `CSS_CTRL_RESET;
            sleep_req_reg <= 1'b0;
        end else begin
            sleep_req_reg <= 1'b0;
            if (bus_req && ack_reg && wb_we_i && wb_sel_i[0]
                && wb_adr_i == `CSS_CTRL_OFF) begin
                ctrl_reg <= wb_dat_i[3:0];
                sleep_req_reg <= wb_dat_i[`CSS_CTRL_SLEEP];
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign internal_reset = rst_out_reg;
    assign core_clock_en = en_reg[0];
    assign program_memory_clock_en = en_reg[1];
    assign peripheral_clock_en = en_reg[2];
    assign converter_clock_en = en_reg[3];
    assign async_timer_clock_en = en_reg[4];
    assign source_select = src_reg;
    assign osc_range = src_sel_reg[3:1];
    assign wake_irq_taken = irq_reg;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_timeout_end;
        state_reg == css_pkg::ST_TIMEOUT ##1
        state_reg == css_pkg::ST_STARTUP;
    endsequence
    sequence s_startup_end;
        state_reg == css_pkg::ST_STARTUP ##1 state_reg == css_pkg::ST_RUN;
    endsequence
    sequence s_leave_sleep;
        state_reg == css_pkg::ST_SLEEP ##1
        state_reg != css_pkg::ST_SLEEP;
    endsequence

    property p_timeout_len;
        s_timeout_end |-> $past(cnt_reg) == to_target - 16'h0001;
    endproperty
    a_timeout_len: assert property (p_timeout_len)
        else $error("time-out ended early");

    property p_reset_held;
        !(run_state || state_reg == css_pkg::ST_SLEEP) |=> rst_out_reg;
    endproperty
    a_reset_held: assert property (p_reset_held)
        else $error("internal reset dropped during start-up");

    property p_wake_path;
        s_leave_sleep |-> state_reg == css_pkg::ST_STARTUP
                          || state_reg == css_pkg::ST_RESET;
    endproperty
    a_wake_path: assert property (p_wake_path)
        else $error("wake went through time-out");

    property p_wake_len;
        s_startup_end ##0 woke_reg |->
            $past(cnt_reg) == timing[15:0] - 16'h0001;
    endproperty
    a_wake_len: assert property (p_wake_len)
        else $error("wake start-up count wrong");

    property p_irq_level;
        irq_reg |-> $past(level_irq_in) && run_state;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("wake interrupt without level");

    property p_same_tick;
        (en_reg[0] || en_reg[2] || en_reg[3]) |-> $past(tick_reg);
    endproperty
    a_same_tick: assert property (p_same_tick)
        else $error("clock enable off the prescaler tick");

    property p_div8;
        !div8_reg && en_reg[0] |=> (!en_reg[0])[*7];
    endproperty
    a_div8: assert property (p_div8)
        else $error("divide by eight broken");

    property p_conv_sleep;
        state_reg == css_pkg::ST_SLEEP && tick_reg
        && !ctrl_reg[`CSS_CTRL_CONV_OFF] |=> en_reg[3] && !en_reg[0];
    endproperty
    a_conv_sleep: assert property (p_conv_sleep)
        else $error("converter clock stopped in sleep");

    property p_flash_core;
        en_reg[1] == en_reg[0];
    endproperty
    a_flash_core: assert property (p_flash_core)
        else $error("program memory clock not with core");

    property p_fuse_hold;
        1'b1 |=> $stable(src_sel_reg) && $stable(su_sel_reg)
                 && $stable(div8_reg);
    endproperty
    a_fuse_hold: assert property (p_fuse_hold)
        else $error("fuses changed while running");

    property p_no_timeout;
        state_reg == css_pkg::ST_RESET && to_target == 16'h0000
        && filt_reg[`CSS_PIN_EXT_RST] |=> state_reg == css_pkg::ST_STARTUP;
    endproperty
    a_no_timeout: assert property (p_no_timeout)
        else $error("zero time-out not skipped");

    property p_async_runs;
        rise_reg[`CSS_PIN_XTAL] && !ctrl_reg[`CSS_CTRL_TIMER_OFF]
        |=> en_reg[4];
    endproperty
    a_async_runs: assert property (p_async_runs)
        else $error("async timer clock missing");

endmodule : css_startup_sequencer

/* dv/clock_source_startup_sequencer_tb_top.sv */
`include "css_defines.svh"
module clock_source_startup_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus, all driven at the rising edge
    logic core_clk = 1'b0, sys_rst = 1'b1, fv = 1'b1, div8 = 1'b1;
    logic ext_rst_n = 1'b1;
    logic wd = 1'b0, osc = 1'b0, xtal = 1'b0, wake = 1'b0, lvl = 1'b0;
    logic [3:0] ck = 4'h0;
    logic [1:0] su_f = 2'h0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rd, dat_o;
    logic ack, irst, c_en, p_en, m_en, v_en, a_en, irq;
    logic [2:0] src, rng;
    // Pulse tallies, taken on the falling edge where outputs are settled
    int fails = 0, checks_done = 0, nc = 0, np = 0, nm = 0, nv = 0, na = 0;
    int ni = 0;
    int d[6];
    initial forever #5 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        nc += c_en;
        np += p_en;
        nm += m_en;
        nv += v_en;
        na += a_en;
        ni += irq;
    end
    css_startup_sequencer u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .ext_reset_n_pin(ext_rst_n), .watchdog_osc_in(wd), .osc_clk_in(osc),
        .async_xtal_in(xtal), .clock_source_select_fuses(ck),
        .startup_time_fuses(su_f), .divide_by_eight_fuse(div8),
        .fuses_valid(fv), .wake_event(wake), .level_irq_in(lvl),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .internal_reset(irst), .core_clock_en(c_en),
        .peripheral_clock_en(p_en), .program_memory_clock_en(m_en),
        .converter_clock_en(v_en), .async_timer_clock_en(a_en),
        .source_select(src), .osc_range(rng), .wake_irq_taken(irq));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    // One classic Wishbone cycle; held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) fails++;
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge core_clk);
    endtask : wb
    // Square pulses on a foreign clock pin, four core cycles per level
    task pulse(input int w, input int n);
        repeat (n) begin
            for (int l = 1; l >= 0; l--) begin
                @(posedge core_clk);
                case (w)
                    1: wd <= l[0];
                    2: osc <= l[0];
                    default: xtal <= l[0];
                endcase
                repeat (3) @(posedge core_clk);
            end
        end
        repeat (8) @(posedge core_clk);
    endtask : pulse
    task restart(input logic [3:0] c, input logic [1:0] s, input logic v);
        @(posedge core_clk);
        ck <= c;
        su_f <= s;
        div8 <= v;
        sys_rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : restart
    // Enable pulses counted over a window of n cycles
    task measure(input int n);
        d = '{nc, np, nm, nv, na, ni};
        repeat (n) @(posedge core_clk);
        d = '{nc - d[0], np - d[1], nm - d[2],
              nv - d[3], na - d[4], ni - d[5]};
    endtask : measure
    function automatic logic [2:0] exp_src(input logic [3:0] c);
        if (c[3]) return 3'h0;
        case (c[2:0])
            3'h7, 3'h6: return 3'h1;
            3'h5, 3'h4: return 3'h2;
            3'h3: return 3'h3;
            3'h2: return 3'h4;
            3'h0: return 3'h5;
            default: return 3'h6;
        endcase
    endfunction : exp_src
    // Cut a hang short well after the expected run length
    initial begin
        #600000;
        fails++;
        give_verdict();
    end
    initial begin
        // Invalid fuse array falls back to the shipped setting
        fv <= 1'b0;
        restart(4'hf, 2'h3, 1'b1);
        wb(1'b0, `CSS_STATUS_OFF, 32'h0);
        check(rd[12:3], {3'h4, 1'b0, 2'h2, 4'h2});
        fv <= 1'b1;
        // Every source code decodes to its source and range
        for (int c = 0; c < 16; c++) begin
            restart(c[3:0], 2'h0, 1'b1);
            check(src, exp_src(c[3:0]));
            check(rng, c[3:1]);
        end
        // Time-out of 512 watchdog cycles precedes the start-up count
        restart(4'h0, 2'h1, 1'b1);
        pulse(1, 511);
        wb(1'b0, `CSS_STATUS_OFF, 32'h0);
        check(rd[2:0], 3'h1);
        pulse(1, 1);
        wb(1'b0, `CSS_STATUS_OFF, 32'h0);
        check(rd[2:0], 3'h2);
        // No time-out: six plus fourteen oscillator edges release reset
        restart(4'h0, 2'h0, 1'b1);
        pulse(2, 19);
        check(irst, 1'b1);
        pulse(2, 1);
        check(irst, 1'b0);
        measure(16);
        check(d[0], 16);
        check(d[2], 16);
        wb(1'b1, `CSS_CTRL_OFF, 32'h1);
        measure(16);
        check(d[2], 0);
        check(d[1], 16);
        wb(1'b0, `CSS_CTRL_OFF, 32'h0);
        check(rd, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, `CSS_CTRL_OFF, 32'h0);
        // Sleep: converter and timer domains keep running
        wb(1'b1, `CSS_CTRL_OFF, 32'h10);
        repeat (3) @(posedge core_clk);
        measure(16);
        check(d[3], 16);
        check(d[0], 0);
        d[4] = na;
        d[0] = nc;
        pulse(3, 3);
        check(nc - d[0], 0);
        check(na - d[4], 3);
        // Wake by a level that vanishes: no interrupt, start-up only
        lvl <= 1'b1;
        repeat (6) @(posedge core_clk);
        lvl <= 1'b0;
        d[5] = ni;
        pulse(2, 6);
        wb(1'b0, `CSS_STATUS_OFF, 32'h0);
        check(rd[2:0], 3'h3);
        check(ni - d[5], 0);
        // Wake by a held level: the interrupt is taken once
        wb(1'b1, `CSS_CTRL_OFF, 32'h10);
        repeat (3) @(posedge core_clk);
        lvl <= 1'b1;
        pulse(2, 6);
        check(ni - d[5], 1);
        lvl <= 1'b0;
        // Wake by the event line alone: start-up only, no interrupt
        wb(1'b1, `CSS_CTRL_OFF, 32'h10);
        repeat (3) @(posedge core_clk);
        wake <= 1'b1;
        d[5] = ni;
        pulse(2, 6);
        wake <= 1'b0;
        wb(1'b0, `CSS_STATUS_OFF, 32'h0);
        check({rd[14:13], rd[2:0]}, 5'h13);
        check(ni - d[5], 0);
        // Programmed divide fuse: one tick in eight
        restart(4'h0, 2'h0, 1'b0);
        pulse(2, 20);
        measure(64);
        check(d[0], 8);
        // External reset pin restarts the full reset start-up
        ext_rst_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        check(irst, 1'b1);
        ext_rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        pulse(2, 19);
        check(irst, 1'b1);
        pulse(2, 1);
        check(irst, 1'b0);
        give_verdict();
    end
endmodule : clock_source_startup_sequencer_tb_top
